/* File: rtl/stc_pkg.sv */
// Shared constants, register map and carrier types of the 16-bit timer/counter.
package stc_pkg;

   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   localparam int          PS_W          = 3;

   // Register byte offsets.
   localparam logic [7:0]  CTRL_OFF      = 8'h00;
   localparam logic [7:0]  CNT_LO_OFF    = 8'h04;
   localparam logic [7:0]  CNT_HI_OFF    = 8'h08;
   localparam logic [7:0]  FLAG_OFF      = 8'h0c;
   localparam logic [7:0]  IEN_OFF       = 8'h10;

   // Control register: writable bits and reset value.
   localparam logic [7:0]  CTRL_WMASK    = 8'hbf;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam int          FLAG_BIT      = 0;
   localparam int          IEN_BIT       = 0;

   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_MAX     = 16'hffff;

   // System clock rate and the divide from it to the instruction clock.
   localparam int          CLK_HZ        = 20_000_000;
   localparam logic [1:0]  INSTR_LAST    = 2'h3;

   // Control register layout, bit 7 down to bit 0.
   typedef struct packed {
      logic       wide;
      logic       sysclk_stat;
      logic [1:0] ps;
      logic       osc_en;
      logic       sync_bypass;
      logic       src_ext;
      logic       run;
   } stc_ctrl_t;

   typedef enum logic [2:0] {
      MODE_TIMER = 3'b001,
      MODE_SYNC  = 3'b010,
      MODE_ASYNC = 3'b100
   } stc_mode_t;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } stc_apb_req_t;

   typedef struct packed {
      logic              pready;
      logic [DATA_W-1:0] prdata;
      logic              pslverr;
   } stc_apb_rsp_t;

   typedef struct packed {
      stc_ctrl_t    ctrl;
      logic [15:0]  count;
      logic [7:0]   hi_buf;
      logic         flag;
      logic         ien;
      logic         irq;
      logic [1:0]   itick_cnt;
      logic         itick;
      logic         ext_s1;
      logic         ext_s2;
      logic         ext_s3;
      logic         asy_s1;
      logic         asy_s2;
      logic         asy_s3;
      logic         clr_tog;
      stc_apb_rsp_t rsp;
      logic [1:0]   osc_oe;
      logic [1:0]   osc_rd;
      logic         osc_run;
   } stc_state_t;

   localparam stc_state_t STATE_RESET = '0;

   typedef struct packed {
      logic            clr_s1;
      logic            clr_s2;
      logic            clr_s3;
      logic [PS_W-1:0] cnt;
      logic            pulse;
      logic            toggle;
   } stc_pre_state_t;

   localparam stc_pre_state_t PRE_RESET = '0;

endpackage

/* File: rtl/stc_prescale.sv */
// Count prescaler dividing its tick by 1, 2, 4 or 8.
`timescale 1ns/1ps
module stc_prescale
   import stc_pkg::*;
(
   // Clock and reset.
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       clk_en,
   // Count input and ratio.
   input  wire logic       tick,
   input  wire logic [1:0] ratio_sel,
   // Clear request, one toggle per clear, from any domain.
   input  wire logic       clr_toggle,
   // Divided output.
   output logic            pulse,
   output logic            toggle
);
   import stc_pkg::*;

   stc_pre_state_t s;
   stc_pre_state_t n;
   logic [3:0]      span;
   logic [PS_W-1:0] limit;
   logic            clr;

   assign span  = 4'h1 << ratio_sel;
   assign limit = PS_W'(span - 4'h1);
   assign clr   = s.clr_s2 ^ s.clr_s3;

   always_comb
   begin
      n        = s;
      n.clr_s1 = clr_toggle;
      n.clr_s2 = s.clr_s1;
      n.clr_s3 = s.clr_s2;
      n.pulse  = 1'b0;
      if (clr)
      begin
         n.cnt = '0;
      end
      else if (tick)
      begin
         if (s.cnt == limit)
         begin
            n.cnt   = '0;
            n.pulse = 1'b1;
         end
         else
         begin
            n.cnt = s.cnt + PS_W'(1);
         end
      end
      n.toggle = s.toggle ^ n.pulse;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= PRE_RESET;
      end
      else if (clk_en)
      begin
         s <= n;
      end
   end

   assign pulse  = s.pulse;
   assign toggle = s.toggle;

endmodule // stc_prescale

/* File: rtl/stc_timer.sv */
// 16-bit timer/counter with APB register access.
// Notes on behaviour
// - Counts only while run bit set
// - 16-bit count wraps FFFF to 0, flags
// - Bit 7 picks 16-bit or byte access
// - Bit 6 shows system clock from oscillator
// - Prescale 1, 2, 4 or 8
// - Bit 3 switches slow oscillator
// - Oscillator pins inputs, read as zero
// - Bit 2 bypasses external clock synchroniser
// - Internal source ignores synchroniser bit
// - Bit 1 picks external or instruction clock
// - Advance per instruction or rising edge
// - Timer, synchronous, asynchronous counter modes
// - Special event trigger clears the count
// - Oscillator keeps running in low power
// - Overflow flag, interrupt when enabled
// - Low byte access moves high buffer
// - Only low byte writes clear prescaler
// - Write beats trigger; trigger never flags
`timescale 1ns/1ps
module stc_timer
   import stc_pkg::*;
(
   // Clock, reset and clock enable.
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         pclk_en,
   // Register bus.
   input  stc_pkg::stc_apb_req_t apb_req,
   output stc_pkg::stc_apb_rsp_t apb_rsp,
   // Count sources and events.
   input  wire logic         ext_count_clock_pin,
   input  wire logic         slow_osc_in,
   input  wire logic         sevt_reset,
   input  wire logic         sysclk_from_slow_osc,
   // Oscillator pin sharing with the port.
   input  wire logic [1:0]   osc_pin_in,
   input  wire logic [1:0]   osc_pin_direction_bits,
   output logic [1:0]        osc_pin_oe,
   output logic [1:0]        osc_pin_read,
   // Oscillator and interrupt.
   output logic              slow_osc_run,
   output logic              overflow_irq
);
   import stc_pkg::*;

   stc_state_t s;
   stc_state_t n;
   stc_mode_t  mode;
   logic       src_clk;
   logic       pre_tick;
   logic       pre_pulse;
   logic       asy_toggle;
   logic       asy_edge;
   logic       count_inc;
   logic       acc;
   logic       prep;
   logic       done_wr;
   logic       wr_lo;
   logic       wr_hi;
   logic       wr_flag;
   logic       rd_lo;
   logic       flag_set;
   logic       mapped;

   // Source pin: the slow oscillator when enabled, else the clock pin.
   assign src_clk = s.ctrl.osc_en ? slow_osc_in : ext_count_clock_pin;

   always_comb
   begin
      case ({s.ctrl.src_ext, s.ctrl.sync_bypass})
         2'b10:   mode = MODE_SYNC;
         2'b11:   mode = MODE_ASYNC;
         default: mode = MODE_TIMER;
      endcase
   end

   // Bus decode.
   assign acc     = apb_req.psel & apb_req.penable;
   assign prep    = acc & ~s.rsp.pready;
   assign done_wr = acc & s.rsp.pready & apb_req.pwrite & ~s.rsp.pslverr;
   assign wr_lo   = done_wr & (apb_req.paddr == CNT_LO_OFF);
   assign wr_hi   = done_wr & (apb_req.paddr == CNT_HI_OFF);
   assign wr_flag = done_wr & (apb_req.paddr == FLAG_OFF);
   assign rd_lo   = prep & ~apb_req.pwrite & (apb_req.paddr == CNT_LO_OFF);
   assign mapped  = (apb_req.paddr == CTRL_OFF) | (apb_req.paddr == CNT_LO_OFF) |
                    (apb_req.paddr == CNT_HI_OFF) | (apb_req.paddr == FLAG_OFF) |
                    (apb_req.paddr == IEN_OFF);

   // Prescaler tick in the system clock domain.
   always_comb
   begin
      case (mode)
         MODE_TIMER: pre_tick = s.ctrl.run & s.itick;
         MODE_SYNC:  pre_tick = s.ctrl.run & s.ext_s2 & ~s.ext_s3;
         MODE_ASYNC: pre_tick = 1'b0;
         default:    pre_tick = 1'b0;
      endcase
   end

   stc_prescale u_pre_sync (
      .clk        (pclk),
      .rst_n      (presetn),
      .clk_en     (pclk_en),
      .tick       (pre_tick),
      .ratio_sel  (s.ctrl.ps),
      .clr_toggle (s.clr_tog),
      .pulse      (pre_pulse),
      .toggle     ()
   );

   // Runs on the source pin itself; its ratio is a static setting there.
   stc_prescale u_pre_async (
      .clk        (src_clk),
      .rst_n      (presetn),
      .clk_en     (1'b1),
      .tick       (1'b1),
      .ratio_sel  (s.ctrl.ps),
      .clr_toggle (s.clr_tog),
      .pulse      (),
      .toggle     (asy_toggle)
   );

   assign asy_edge  = s.asy_s2 ^ s.asy_s3;
   assign count_inc = s.ctrl.run & ((mode == MODE_ASYNC) ? asy_edge : pre_pulse);
   assign flag_set  = count_inc & (s.count == COUNT_MAX);

   always_comb
   begin
      n = s;
      // Instruction clock, one tick in four system clocks.
      n.itick_cnt = s.itick_cnt + 2'h1;
      n.itick     = (s.itick_cnt == INSTR_LAST);
      n.ext_s1    = src_clk;
      n.ext_s2    = s.ext_s1;
      n.ext_s3    = s.ext_s2;
      n.asy_s1    = asy_toggle;
      n.asy_s2    = s.asy_s1;
      n.asy_s3    = s.asy_s2;
      if (count_inc)
      begin
         n.count = s.count + 16'h0001;
      end
      if (sevt_reset)
      begin
         n.count = COUNT_RESET;
      end
      if (wr_lo)
      begin
         n.count[7:0] = apb_req.pwdata[7:0];
         n.clr_tog    = ~s.clr_tog;
         if (s.ctrl.wide)
         begin
            n.count[15:8] = s.hi_buf;
         end
         else if (sevt_reset)
         begin
            n.count[15:8] = s.count[15:8];
         end
      end
      if (wr_hi)
      begin
         if (s.ctrl.wide)
         begin
            n.hi_buf = apb_req.pwdata[7:0];
         end
         else
         begin
            n.count[15:8] = apb_req.pwdata[7:0];
            if (sevt_reset)
            begin
               n.count[7:0] = s.count[7:0];
            end
         end
      end
      if (done_wr && apb_req.paddr == CTRL_OFF)
      begin
         n.ctrl = stc_ctrl_t'((apb_req.pwdata[7:0] & CTRL_WMASK) | (CTRL_RESET & ~CTRL_WMASK));
      end
      if (done_wr && apb_req.paddr == IEN_OFF)
      begin
         n.ien = apb_req.pwdata[IEN_BIT];
      end
      n.ctrl.sysclk_stat = sysclk_from_slow_osc;
      // A new overflow wins over a clear in the same cycle; the trigger never sets it.
      n.flag = flag_set | (s.flag & ~(wr_flag & ~apb_req.pwdata[FLAG_BIT]));
      n.irq  = s.flag & s.ien;
      // Bus answer: one wait state, then pready for one cycle.
      n.rsp.pready  = prep;
      n.rsp.pslverr = prep & ~mapped;
      n.rsp.prdata  = '0;
      if (prep && !apb_req.pwrite)
      begin
         case (apb_req.paddr)
            CTRL_OFF:   n.rsp.prdata[7:0] = s.ctrl;
            CNT_LO_OFF: n.rsp.prdata[7:0] = s.count[7:0];
            CNT_HI_OFF: n.rsp.prdata[7:0] = s.ctrl.wide ? s.hi_buf : s.count[15:8];
            FLAG_OFF:   n.rsp.prdata[FLAG_BIT] = s.flag;
            IEN_OFF:    n.rsp.prdata[IEN_BIT] = s.ien;
            default:    n.rsp.prdata = '0;
         endcase
      end
      if (rd_lo && s.ctrl.wide)
      begin
         n.hi_buf = s.count[15:8];
      end
      // The oscillator pins are taken over while the oscillator is on.
      n.osc_oe  = s.ctrl.osc_en ? 2'b00 : ~osc_pin_direction_bits;
      n.osc_rd  = s.ctrl.osc_en ? 2'b00 : osc_pin_in;
      n.osc_run = s.ctrl.osc_en;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s <= STATE_RESET;
      end
      else if (pclk_en)
      begin
         s <= n;
      end
   end

   assign apb_rsp      = s.rsp;
   assign osc_pin_oe   = s.osc_oe;
   assign osc_pin_read = s.osc_rd;
   // The enable has no power-mode gating, so the oscillator keeps running.
   assign slow_osc_run = s.osc_run;
   assign overflow_irq = s.irq;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_hold_off;
      pclk_en && !s.ctrl.run && !wr_lo && !wr_hi && !sevt_reset |=> s.count == $past(s.count);
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("count moved while stopped");

   property p_rollover;
      pclk_en && count_inc && s.count == COUNT_MAX && !wr_lo && !wr_hi && !sevt_reset
         |=> s.count == COUNT_RESET && s.flag;
   endproperty
   a_rollover: assert property (p_rollover) else $error("rollover did not clear and flag");

   property p_wide_read;
      pclk_en && rd_lo && s.ctrl.wide |=> s.hi_buf == $past(s.count[15:8]);
   endproperty
   a_wide_read: assert property (p_wide_read) else $error("high buffer not loaded on low read");

   property p_wide_write;
      pclk_en && wr_lo && s.ctrl.wide |=> s.count[15:8] == $past(s.hi_buf) && s.count[7:0] == $past(apb_req.pwdata[7:0]);
   endproperty
   a_wide_write: assert property (p_wide_write) else $error("16-bit write not applied at once");

   property p_stat;
      pclk_en ##1 pclk_en |-> s.ctrl.sysclk_stat == $past(sysclk_from_slow_osc);
   endproperty
   a_stat: assert property (p_stat) else $error("clock status bit wrong");

   property p_osc_pins;
      pclk_en && s.ctrl.osc_en |=> osc_pin_read == 2'b00 && osc_pin_oe == 2'b00;
   endproperty
   a_osc_pins: assert property (p_osc_pins) else $error("oscillator pins not taken over");

   property p_sevt;
      pclk_en && sevt_reset && !wr_lo && !wr_hi |=> s.count == COUNT_RESET;
   endproperty
   a_sevt: assert property (p_sevt) else $error("trigger did not clear count");

   property p_sevt_write;
      pclk_en && sevt_reset && wr_lo && !s.ctrl.wide |=> s.count[7:0] == $past(apb_req.pwdata[7:0]);
   endproperty
   a_sevt_write: assert property (p_sevt_write) else $error("trigger beat a write");

   property p_sevt_noflag;
      pclk_en && sevt_reset && !count_inc && !s.flag |=> !s.flag;
   endproperty
   a_sevt_noflag: assert property (p_sevt_noflag) else $error("trigger set overflow flag");

   property p_irq;
      pclk_en && s.flag && s.ien |=> overflow_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_sync_edge;
      pclk_en && mode == MODE_SYNC && s.ctrl.run && s.ext_s2 && !s.ext_s3 |-> pre_tick;
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("synchronised edge lost");

   c_overflow: cover property (pclk_en && flag_set);
   c_wide_rd:  cover property (rd_lo && s.ctrl.wide);
   c_async:    cover property (mode == MODE_ASYNC && count_inc);
   c_sevt_wr:  cover property (sevt_reset && wr_lo);

endmodule // stc_timer

/* File: test/tb.sv */
// Self-checking testbench of the 16-bit timer/counter.
`timescale 1ns/1ps
module tb;
   import stc_pkg::*;
   logic         pclk;
   logic         presetn;
   logic         clk_en;
   int           m_cnt;
   stc_apb_req_t req;
   stc_apb_rsp_t rsp;
   logic         ext_pin;
   logic         osc_in;
   logic         sevt;
   logic         sys_osc;
   logic [1:0]   pin_in;
   logic [1:0]   pin_dir;
   logic [1:0]   pin_oe;
   logic [1:0]   pin_rd;
   logic         osc_run;
   logic         irq;
   logic [31:0]  seed;
   logic [31:0]  rd;
   logic [31:0]  v;
   logic         err;
   logic [7:0]   m_ctrl;
   logic [15:0]  c;
   logic [15:0]  c0;
   logic [7:0]   tbl [5];
   int           fail_count;
   int           tests_run;
   int           cyc = 0;

   stc_timer stc_timer_inst (
      .pclk                   (pclk),
      .presetn                (presetn),
      .pclk_en                (clk_en),
      .apb_req                (req),
      .apb_rsp                (rsp),
      .ext_count_clock_pin    (ext_pin),
      .slow_osc_in            (osc_in),
      .sevt_reset             (sevt),
      .sysclk_from_slow_osc   (sys_osc),
      .osc_pin_in             (pin_in),
      .osc_pin_direction_bits (pin_dir),
      .osc_pin_oe             (pin_oe),
      .osc_pin_read           (pin_rd),
      .slow_osc_run           (osc_run),
      .overflow_irq           (irq)
   );

   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic test_done();
      $display("TB: checks %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge pclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fail_count++;
         $display("[ERR] %0t run did not finish", $time);
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      tests_run++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t %s: got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // One APB transfer; trig raises the event trigger in the completing access cycle.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic trig);
      int n;
      n = 0;
      @(posedge pclk);
      req.psel    <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite  <= wr;
      req.paddr   <= a;
      req.pwdata  <= d;
      @(posedge pclk);
      req.penable <= 1'b1;
      @(posedge pclk);
      sevt <= trig;
      // Read right at an edge, the response shows what stood before that edge.
      while (rsp.pready !== 1'b1 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20)
      begin
         fail_count++;
         $display("[ERR] %0t no bus answer", $time);
      end
      rd  = rsp.prdata;
      err = rsp.pslverr;
      req.psel    <= 1'b0;
      req.penable <= 1'b0;
      sevt        <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 1'b0);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 1'b0);
      chk(rd, exp, "register read");
   endtask

   task automatic ctrl(input logic [7:0] d);
      wr(CTRL_OFF, {24'h0, d});
      m_ctrl = d & CTRL_WMASK;
   endtask

   task automatic set_cnt(input logic [15:0] d);
      wr(CNT_HI_OFF, {24'h0, d[15:8]});
      wr(CNT_LO_OFF, {24'h0, d[7:0]});
      m_cnt = d;
   endtask

   task automatic get_cnt(output logic [15:0] q);
      apb(1'b0, CNT_LO_OFF, 32'h0, 1'b0);
      q[7:0] = rd[7:0];
      apb(1'b0, CNT_HI_OFF, 32'h0, 1'b0);
      q[15:8] = rd[7:0];
   endtask

   // The selected input rises k times; the ignored one rises twice as often.
   task automatic pulses(input logic osc, input int k);
      for (int j = 0; j < k * 8; j++)
      begin
         @(posedge pclk);
         osc_in  <= osc ? j[2] : j[1];
         ext_pin <= osc ? j[1] : j[2];
      end
      @(posedge pclk);
      osc_in  <= 1'b0;
      ext_pin <= 1'b0;
   endtask

   initial
   begin
      req = '0;
      presetn = 1'b0;
      clk_en = 1'b1;
      m_cnt = 0;
      ext_pin = 1'b0;
      osc_in = 1'b0;
      sevt = 1'b0;
      sys_osc = 1'b0;
      pin_in = 2'b00;
      pin_dir = 2'b11;
      seed = 32'h9d43;
      fail_count = 0;
      tests_run = 0;
      tbl = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h05};
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 5; i++)
         rdchk(8'(i * 4), 32'h0);
      apb(1'b0, 8'h14, 32'h0, 1'b0);
      chk({31'h0, err}, 32'h1, "unmapped address error");
      sys_osc <= 1'b1;
      ctrl(8'hc0);
      rdchk(CTRL_OFF, {24'h0, m_ctrl | 8'h40});
      sys_osc <= 1'b0;
      ctrl(8'h40);
      rdchk(CTRL_OFF, {24'h0, m_ctrl});
      v = rnd();
      set_cnt(v[15:0]);
      repeat (40) @(posedge pclk);
      get_cnt(c);
      chk({16'h0, c}, 32'(m_cnt), "count held while stopped");
      foreach (tbl[i])
      begin
         set_cnt(16'h0);
         ctrl(tbl[i]);
         repeat (256) @(posedge pclk);
         ctrl(8'h00);
         get_cnt(c);
         v = 64 >> tbl[i][5:4];
         chk({31'h0, c + 16'h1 >= v[15:0] && c <= v[15:0] + 16'h1}, 32'h1, "timer rate");
      end
      set_cnt(16'hfffe);
      wr(IEN_OFF, 32'h1);
      ctrl(8'h01);
      repeat (20) @(posedge pclk);
      ctrl(8'h00);
      rdchk(FLAG_OFF, 32'h1);
      chk({31'h0, irq}, 32'h1, "irq with enable");
      get_cnt(c);
      chk({31'h0, c < 16'h8}, 32'h1, "count wrapped");
      wr(IEN_OFF, 32'h0);
      repeat (2) @(posedge pclk);
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(IEN_OFF, 32'h1);
      wr(FLAG_OFF, 32'h1);
      rdchk(FLAG_OFF, 32'h1);
      wr(FLAG_OFF, 32'h0);
      rdchk(FLAG_OFF, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq after flag clear");
      set_cnt(16'h1234);
      @(posedge pclk);
      sevt <= 1'b1;
      @(posedge pclk);
      sevt <= 1'b0;
      m_cnt = 0;
      get_cnt(c);
      chk({16'h0, c}, 32'(m_cnt), "trigger clears count");
      rdchk(FLAG_OFF, 32'h0);
      set_cnt(16'h1234);
      apb(1'b1, CNT_LO_OFF, 32'h55, 1'b1);
      // A byte write against the trigger keeps the other byte.
      m_cnt = (m_cnt & 32'hff00) | 32'h55;
      get_cnt(c);
      chk({16'h0, c}, 32'(m_cnt), "write beats trigger");
      ctrl(8'h80);
      wr(CNT_HI_OFF, 32'hab);
      apb(1'b0, CNT_LO_OFF, 32'h0, 1'b0);
      rdchk(CNT_HI_OFF, 32'(m_cnt >> 8));
      wr(CNT_HI_OFF, 32'hab);
      wr(CNT_LO_OFF, 32'hcd);
      rdchk(CNT_LO_OFF, 32'hcd);
      rdchk(CNT_HI_OFF, 32'hab);
      ctrl(8'h00);
      rdchk(CNT_HI_OFF, 32'hab);
      for (int i = 0; i < 4; i++)
      begin
         v = rnd();
         pin_in <= v[1:0];
         pin_dir <= v[3:2];
         ctrl({4'h0, i[0], 3'h0});
         repeat (2) @(posedge pclk);
         chk({30'h0, pin_oe}, i[0] ? 32'h0 : {30'h0, ~v[3:2]}, "pin enable");
         chk({30'h0, pin_rd}, i[0] ? 32'h0 : {30'h0, v[1:0]}, "pin read");
         chk({31'h0, osc_run}, {31'h0, i[0]}, "oscillator run");
      end
      tbl = '{8'h03, 8'h07, 8'h0b, 8'h0f, 8'h03};
      for (int i = 0; i < 4; i++)
      begin
         set_cnt(16'h0);
         ctrl(tbl[i]);
         if (tbl[i][3])
            repeat (20) @(posedge pclk);
         pulses(tbl[i][3], 4);
         repeat (10) @(posedge pclk);
         get_cnt(c0);
         pulses(tbl[i][3], 5);
         repeat (10) @(posedge pclk);
         get_cnt(c);
         chk({16'h0, c - c0}, 32'h5, "external edges counted");
         ctrl(8'h00);
      end
      // With the clock enable low the running timer must not advance.
      set_cnt(16'h0);
      ctrl(8'h01);
      clk_en <= 1'b0;
      repeat (40) @(posedge pclk);
      clk_en <= 1'b1;
      ctrl(8'h00);
      get_cnt(c);
      chk({31'h0, c <= 16'h3}, 32'h1, "count frozen by clock enable");
      test_done();
   end
endmodule // tb
